// ==== dscg_pkg.sv ====
`default_nettype none
package dscg_pkg;

   // ==========================================================================
   // Register map, byte addresses on the APB.
   localparam logic [11:0] RUN_GATE_OFS   = 12'h104;
   localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
   localparam logic [11:0] DEEP_GATE_OFS  = 12'h124;
   localparam logic [11:0] CTRL_OFS       = 12'h200;
   localparam logic [11:0] IRQ_STAT_OFS   = 12'h204;
   localparam logic [11:0] IRQ_MASK_OFS   = 12'h208;

   // ==========================================================================
   // Gating register layout, shared by the run, sleep and deep-sleep banks.
   localparam int unsigned BIT_CMP1  = 25;
   localparam int unsigned BIT_CMP0  = 24;
   localparam int unsigned BIT_GPA   = 18;
   localparam int unsigned BIT_GPB   = 17;
   localparam int unsigned BIT_GPC   = 16;
   localparam int unsigned BIT_SSI   = 4;
   localparam int unsigned BIT_UART  = 0;
   localparam logic [31:0] GATE_WMASK = 32'h0307_0011;
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   localparam int unsigned NUM_UNITS  = 7;

   // ==========================================================================
   // Control and interrupt fields.
   localparam int unsigned CTRL_ACG_BIT = 0;
   localparam int unsigned IRQ_FAULT    = 0;
   localparam int unsigned IRQ_DEEP     = 1;
   localparam int unsigned IRQ_WAKE     = 2;
   localparam int unsigned IRQ_W        = 3;

   // Power state of the system, one-hot.
   typedef enum logic [2:0] {
      MODE_RUN   = 3'h1,
      MODE_SLEEP = 3'h2,
      MODE_DEEP  = 3'h4
   } dscg_mode_t;

   // Gathers the seven unit bits of a gating word into a unit vector.
   function automatic logic [NUM_UNITS-1:0] gateVec(input logic [31:0] r);
      gateVec = {r[BIT_CMP1], r[BIT_CMP0], r[BIT_GPA], r[BIT_GPB],
                 r[BIT_GPC], r[BIT_SSI], r[BIT_UART]};
   endfunction

   // True for every address that the block decodes.
   function automatic logic addrKnown(input logic [11:0] a);
      addrKnown = (a == RUN_GATE_OFS) || (a == SLEEP_GATE_OFS) ||
                  (a == DEEP_GATE_OFS) || (a == CTRL_OFS) ||
                  (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
   endfunction

endpackage
`default_nettype wire

// ==== dscg_unit_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Carries unit enables and peripheral access strobes to the fault guard.
interface dscg_unit_if;
   logic [dscg_pkg::NUM_UNITS-1:0] unitEn;
   logic [dscg_pkg::NUM_UNITS-1:0] unitSel;
   logic                           unitAccess;
   logic                           fault;
   modport ctrl  (output unitEn, output unitSel, output unitAccess, input fault);
   modport guard (input unitEn, input unitSel, input unitAccess, output fault);
endinterface
`default_nettype wire

// ==== dscg_fault_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
module dscg_fault_guard (
   input  wire logic         sys_clk,    // System clock.
   input  wire logic         rstn,       // Asynchronous reset, active low.
   dscg_unit_if.guard        uif         // Enables, access strobes and fault.
);

   typedef struct packed {
      logic fault;
   } dscg_guard_t;

   dscg_guard_t s_r;
   dscg_guard_t s_nxt;

   // ==========================================================================
   // Flags a fault for any access that targets a unit whose clock is off.
   always_comb begin
      s_nxt       = s_r;
      s_nxt.fault = uif.unitAccess && (|(uif.unitSel & ~uif.unitEn));
   end

   // Registers the guard state.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign uif.fault = s_r.fault;

   // ==========================================================================
   // An access to an unclocked unit faults on the next edge.
   property p_gatedFault;
      @(posedge sys_clk) disable iff (!rstn)
         (uif.unitAccess && (|(uif.unitSel & ~uif.unitEn))) |=> uif.fault;
   endproperty
   a_gatedFault: assert property (p_gatedFault)
      else $error("Access to unclocked unit did not fault.");

   // An access that touches only clocked units completes normally.
   property p_cleanAccess;
      @(posedge sys_clk) disable iff (!rstn)
         !(uif.unitAccess && (|(uif.unitSel & ~uif.unitEn))) |=> !uif.fault;
   endproperty
   a_cleanAccess: assert property (p_cleanAccess)
      else $error("Fault raised without a gated access.");

endmodule // dscg_fault_guard
`default_nettype wire

// ==== dscg_gate_ctrl.sv ====
//Contract
//- A set gating bit gives its unit a clock, a clear bit leaves it unclocked.
//- An access to a unit whose gating bit is clear ends in a bus fault.
//- All gating bits are zero after reset, so every unit starts unclocked.
//- The deep-sleep gating register is a 32-bit read/write word at 0x124.
//- Bits 25 and 24 gate analog comparators 1 and 0.
//- Bits 18, 17 and 16 gate general-purpose timers 2, 1 and 0.
//- Bit 4 gates synchronous serial 0 and bit 0 gates asynchronous serial 0.
//- Reserved bits are read-only and read as zero; software preserves them.
//- The deep-sleep enables apply only in deep-sleep; run and sleep use their own banks.
//- Sleep-state banks take effect only while automatic clock gating is on.
`timescale 1ns/1ps
`default_nettype none
module dscg_gate_ctrl (
   input  wire logic        sys_clk,      // System clock, 200 MHz.
   input  wire logic        rstn,         // Asynchronous reset, active low.
   input  wire logic        psel,         // APB select.
   input  wire logic        penable,      // APB enable.
   input  wire logic        pwrite,       // APB direction, high for write.
   input  wire logic [11:0] paddr,        // APB byte address.
   input  wire logic [31:0] pwdata,       // APB write data.
   output logic      [31:0] prdata,       // APB read data.
   output logic             pready,       // APB ready.
   output logic             pslverr,      // APB error for unmapped address.
   input  wire logic        sleepReq,     // Core requests sleep, level.
   input  wire logic        deepSleepReq, // Core requests deep-sleep, level.
   input  wire logic [6:0]  unitSel,      // Units addressed by a fabric access.
   input  wire logic        unitAccess,   // Fabric access strobe to a unit.
   output logic      [6:0]  unitClkEn,    // Per-unit clock enable.
   output logic             unitFault,    // Bus fault for a gated access.
   output logic      [2:0]  powerMode,    // Current power state, one-hot.
   output logic             irq           // Level interrupt.
);

   // ==========================================================================
   // Block state, one packed record.
   typedef struct packed {
      logic [31:0]                    deepGate;
      logic [31:0]                    sleepGate;
      logic [31:0]                    runGate;
      logic                           auto_clock_gating;
      logic [dscg_pkg::IRQ_W-1:0]     irqStat;
      logic [dscg_pkg::IRQ_W-1:0]     irqMask;
      dscg_pkg::dscg_mode_t           mode;
      logic [dscg_pkg::NUM_UNITS-1:0] unitEn;
      logic [31:0]                    rdata;
      logic                           ready;
      logic                           slverr;
      logic                           irq;
   } dscg_ctrl_t;

   localparam dscg_ctrl_t ST_RESET = '{
      deepGate:  dscg_pkg::GATE_RESET,
      sleepGate: dscg_pkg::GATE_RESET,
      runGate:   dscg_pkg::GATE_RESET,
      auto_clock_gating:       1'b0,
      irqStat:   '0,
      irqMask:   '0,
      mode:      dscg_pkg::MODE_RUN,
      unitEn:    '0,
      rdata:     32'h0000_0000,
      ready:     1'b0,
      slverr:    1'b0,
      irq:       1'b0
   };

   dscg_ctrl_t s_r;
   dscg_ctrl_t s_nxt;

   logic                           setupPh;
   logic                           wrEn;
   logic [dscg_pkg::NUM_UNITS-1:0] runVec;
   logic [dscg_pkg::NUM_UNITS-1:0] sleepVec;
   logic [dscg_pkg::NUM_UNITS-1:0] deepVec;
   logic [dscg_pkg::IRQ_W-1:0]     irqEv;
   logic [dscg_pkg::IRQ_W-1:0]     irqClr;

   dscg_unit_if uif ();

   // ==========================================================================
   // Fault guard for peripheral accesses.
   assign uif.unitEn     = s_r.unitEn;
   assign uif.unitSel    = unitSel;
   assign uif.unitAccess = unitAccess;

   dscg_fault_guard u_guard (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .uif     (uif.guard)
   );

   // ==========================================================================
   // Bus phase decode and unit views of the three gating banks.
   assign setupPh  = psel && !penable;
   assign wrEn     = psel && penable && pwrite && s_r.ready;
   assign runVec   = dscg_pkg::gateVec(s_r.runGate);
   assign sleepVec = dscg_pkg::gateVec(s_r.sleepGate);
   assign deepVec  = dscg_pkg::gateVec(s_r.deepGate);

   // Ones written to the status word clear the matching bits.
   always_comb begin
      irqClr = '0;
      if (wrEn && (paddr == dscg_pkg::IRQ_STAT_OFS)) begin
         irqClr = pwdata[dscg_pkg::IRQ_W-1:0];
      end
   end

   // ==========================================================================
   // Next state: registers, power mode, enables, interrupts and bus answer.
   always_comb begin
      s_nxt = s_r;
      irqEv = '0;

      // Register writes land at the access edge; reserved bits stay zero.
      if (wrEn) begin
         case (paddr)
            dscg_pkg::DEEP_GATE_OFS: begin
               s_nxt.deepGate = pwdata & dscg_pkg::GATE_WMASK;
            end
            dscg_pkg::SLEEP_GATE_OFS: begin
               s_nxt.sleepGate = pwdata & dscg_pkg::GATE_WMASK;
            end
            dscg_pkg::RUN_GATE_OFS: begin
               s_nxt.runGate = pwdata & dscg_pkg::GATE_WMASK;
            end
            dscg_pkg::CTRL_OFS: begin
               s_nxt.auto_clock_gating = pwdata[dscg_pkg::CTRL_ACG_BIT];
            end
            dscg_pkg::IRQ_MASK_OFS: begin
               s_nxt.irqMask = pwdata[dscg_pkg::IRQ_W-1:0];
            end
            default: begin
               s_nxt.auto_clock_gating = s_r.auto_clock_gating;
            end
         endcase
      end

      // Sleep states are entered only while automatic gating is on.
      if (!s_r.auto_clock_gating) begin
         s_nxt.mode = dscg_pkg::MODE_RUN;
      end else if (deepSleepReq) begin
         s_nxt.mode = dscg_pkg::MODE_DEEP;
      end else if (sleepReq) begin
         s_nxt.mode = dscg_pkg::MODE_SLEEP;
      end else begin
         s_nxt.mode = dscg_pkg::MODE_RUN;
      end

      // Each state takes its enables from its own bank.
      case (s_r.mode)
         dscg_pkg::MODE_RUN: begin
            s_nxt.unitEn = runVec;
         end
         dscg_pkg::MODE_SLEEP: begin
            s_nxt.unitEn = sleepVec;
         end
         dscg_pkg::MODE_DEEP: begin
            s_nxt.unitEn = deepVec;
         end
         default: begin
            s_nxt.unitEn = runVec;
         end
      endcase

      // Events: gated access, deep-sleep entry, return to run.
      irqEv[dscg_pkg::IRQ_FAULT] = uif.fault;
      irqEv[dscg_pkg::IRQ_DEEP]  = (s_nxt.mode == dscg_pkg::MODE_DEEP) &&
                                   (s_r.mode != dscg_pkg::MODE_DEEP);
      irqEv[dscg_pkg::IRQ_WAKE]  = (s_nxt.mode == dscg_pkg::MODE_RUN) &&
                                   (s_r.mode != dscg_pkg::MODE_RUN);
      // A new event wins over a clear in the same cycle.
      s_nxt.irqStat = (s_r.irqStat & ~irqClr) | irqEv;
      s_nxt.irq     = |(s_r.irqStat & s_r.irqMask);

      // The answer is prepared in the setup phase, ready in the access phase.
      s_nxt.ready  = setupPh;
      s_nxt.slverr = setupPh && !dscg_pkg::addrKnown(paddr);
      s_nxt.rdata  = 32'h0000_0000;
      if (setupPh && !pwrite) begin
         case (paddr)
            dscg_pkg::DEEP_GATE_OFS: begin
               s_nxt.rdata = s_r.deepGate;
            end
            dscg_pkg::SLEEP_GATE_OFS: begin
               s_nxt.rdata = s_r.sleepGate;
            end
            dscg_pkg::RUN_GATE_OFS: begin
               s_nxt.rdata = s_r.runGate;
            end
            dscg_pkg::CTRL_OFS: begin
               s_nxt.rdata = 32'(s_r.auto_clock_gating);
            end
            dscg_pkg::IRQ_STAT_OFS: begin
               s_nxt.rdata = 32'(s_r.irqStat);
            end
            dscg_pkg::IRQ_MASK_OFS: begin
               s_nxt.rdata = 32'(s_r.irqMask);
            end
            default: begin
               s_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ==========================================================================
   // Registers the state; every bank clears on reset.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= ST_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state record, except unitFault, which comes from the guard.
   assign prdata    = s_r.rdata;
   assign pready    = s_r.ready;
   assign pslverr   = s_r.slverr;
   assign unitClkEn = s_r.unitEn;
   assign unitFault = uif.fault;
   assign powerMode = s_r.mode;
   assign irq       = s_r.irq;

   // ==========================================================================
   // Checks.
   sequence s_enterDeep;
      (s_r.mode != dscg_pkg::MODE_DEEP) ##1 (s_r.mode == dscg_pkg::MODE_DEEP);
   endsequence

   sequence s_deepWrite;
      setupPh && pwrite && (paddr == dscg_pkg::DEEP_GATE_OFS) ##1 wrEn;
   endsequence

   property p_deepEntry;
      @(posedge sys_clk) disable iff (!rstn)
         s_enterDeep |-> s_r.irqStat[dscg_pkg::IRQ_DEEP];
   endproperty
   a_deepEntry: assert property (p_deepEntry)
      else $error("Deep-sleep entry did not set its status bit.");

   property p_deepWrite;
      @(posedge sys_clk) disable iff (!rstn)
         s_deepWrite |=> (s_r.deepGate == ($past(pwdata) & dscg_pkg::GATE_WMASK));
   endproperty
   a_deepWrite: assert property (p_deepWrite)
      else $error("Deep-sleep gating write not stored.");

   property p_reservedZero;
      @(posedge sys_clk) disable iff (!rstn)
         (setupPh && !pwrite && (paddr == dscg_pkg::DEEP_GATE_OFS))
            |=> ((prdata & ~dscg_pkg::GATE_WMASK) == 32'h0000_0000) && pready;
   endproperty
   a_reservedZero: assert property (p_reservedZero)
      else $error("Reserved gating bits read nonzero.");

   property p_deepApply;
      @(posedge sys_clk) disable iff (!rstn)
         (s_r.mode == dscg_pkg::MODE_DEEP) |=> (unitClkEn == $past(deepVec));
   endproperty
   a_deepApply: assert property (p_deepApply)
      else $error("Deep-sleep enables not applied.");

   property p_sleepApply;
      @(posedge sys_clk) disable iff (!rstn)
         (s_r.mode == dscg_pkg::MODE_SLEEP) |=> (unitClkEn == $past(sleepVec));
   endproperty
   a_sleepApply: assert property (p_sleepApply)
      else $error("Sleep enables not applied.");

   property p_acgOff;
      @(posedge sys_clk) disable iff (!rstn)
         !s_r.auto_clock_gating |=> (powerMode == dscg_pkg::MODE_RUN) ##1 (unitClkEn == $past(runVec));
   endproperty
   a_acgOff: assert property (p_acgOff)
      else $error("Sleep banks used with automatic gating off.");

   property p_irqLevel;
      @(posedge sys_clk) disable iff (!rstn)
         (|(s_r.irqStat & s_r.irqMask)) |=> irq;
   endproperty
   a_irqLevel: assert property (p_irqLevel)
      else $error("Unmasked status did not raise the interrupt.");

   property p_unmapped;
      @(posedge sys_clk) disable iff (!rstn)
         (setupPh && !dscg_pkg::addrKnown(paddr)) |=> (pready && pslverr);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("Unmapped address not answered with an error.");

   // The bus answer stands for one cycle only.
   property p_readyPulse;
      @(posedge sys_clk) disable iff (!rstn)
         pready |=> !pready;
   endproperty
   a_readyPulse: assert property (p_readyPulse)
      else $error("Ready stood for more than one cycle.");

   // A guard fault is recorded in the status word on the next edge.
   property p_faultStatus;
      @(posedge sys_clk) disable iff (!rstn)
         uif.fault |=> s_r.irqStat[dscg_pkg::IRQ_FAULT];
   endproperty
   a_faultStatus: assert property (p_faultStatus)
      else $error("Gated access fault not recorded in status.");

   // Leaving a sleep state records the wake event and restores the run bank.
   sequence s_wake;
      (s_r.mode != dscg_pkg::MODE_RUN) ##1 (s_r.mode == dscg_pkg::MODE_RUN);
   endsequence

   property p_wake;
      @(posedge sys_clk) disable iff (!rstn)
         s_wake |-> s_r.irqStat[dscg_pkg::IRQ_WAKE] ##1 (unitClkEn == $past(runVec));
   endproperty
   a_wake: assert property (p_wake)
      else $error("Wake did not restore the run enables.");

endmodule // dscg_gate_ctrl
`default_nettype wire

// ==== test_deep_sleep_clock_gating_reg1.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_deep_sleep_clock_gating_reg1;
   // ==========================================================================
   // Stimulus and observed signals.
   logic        sys_clk;      // System clock, 200 MHz.
   logic        rstn;         // Reset, active low.
   logic        psel;         // APB select.
   logic        penable;      // APB enable.
   logic        pwrite;       // APB direction.
   logic [11:0] paddr;        // APB address.
   logic [31:0] pwdata;       // APB write data.
   logic [31:0] prdata;       // APB read data.
   logic        pready;       // APB ready.
   logic        pslverr;      // APB error.
   logic        sleepReq;     // Sleep request.
   logic        deepSleepReq; // Deep-sleep request.
   logic [6:0]  unitSel;      // Units addressed by an access.
   logic        unitAccess;   // Access strobe.
   logic [6:0]  unitClkEn;    // Clock enables.
   logic        unitFault;    // Bus fault pulse.
   logic [2:0]  powerMode;    // Power state.
   logic        irq;          // Interrupt.
   int          failures;     // Mismatch count.
   int          n_tests;      // Comparison count.
   int          unitPos[7] = '{0, 4, 16, 17, 18, 24, 25};

   dscg_gate_ctrl u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleepReq(sleepReq), .deepSleepReq(deepSleepReq), .unitSel(unitSel),
      .unitAccess(unitAccess), .unitClkEn(unitClkEn), .unitFault(unitFault),
      .powerMode(powerMode), .irq(irq)
   );

   // The clock toggles every half period of 2.5 ns.
   always #2.5 sys_clk = ~sys_clk;

   // ==========================================================================
   // Shared tasks.
   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Compares one value and counts the result.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the request stands until pready is seen at a rising edge.
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
      int i;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         failures++;
         test_done();
      end
      rdata = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Writes a register and expects a normal completion.
   task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
      logic [31:0] d;
      logic        e;
      apb(1'b1, addr, wdata, d, e);
      chk("write error flag", 32'h0000_0000, {31'h0, e});
   endtask

   // Reads a register and compares its value.
   task automatic rd(input string what, input logic [11:0] addr, input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      apb(1'b0, addr, 32'h0000_0000, d, e);
      chk("read error flag", 32'h0000_0000, {31'h0, e});
      chk(what, exp, d);
   endtask

   // Lets a number of clock edges pass.
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Makes one fabric access and counts fault pulses that follow it.
   task automatic access(input logic [6:0] sel, output int pulses);
      int i;
      pulses = 0;
      @(posedge sys_clk);
      unitSel    <= sel;
      unitAccess <= 1'b1;
      @(posedge sys_clk);
      unitAccess <= 1'b0;
      for (i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         if (unitFault === 1'b1) pulses++;
      end
   endtask

   // ==========================================================================
   // Scenarios.
   // Outputs and the deep and run gating banks after reset.
   task automatic t_reset();
      chk("clock enables", 32'h0000_0000, {25'h0, unitClkEn});
      chk("power mode", 32'h0000_0001, {29'h0, powerMode});
      chk("irq", 32'h0000_0000, {31'h0, irq});
      rd("deep gate", dscg_pkg::DEEP_GATE_OFS, 32'h0000_0000);
      rd("run gate", dscg_pkg::RUN_GATE_OFS, 32'h0000_0000);
      $display("test reset done");
   endtask

   // Writable and reserved bits of the deep gate, and unmapped addresses.
   task automatic t_regmap();
      logic [31:0] d;
      logic        e;
      wr(dscg_pkg::DEEP_GATE_OFS, 32'hFFFF_FFFF);
      rd("deep gate ones", dscg_pkg::DEEP_GATE_OFS, 32'h0307_0011);
      wr(dscg_pkg::DEEP_GATE_OFS, 32'hFCF8_FFEE);
      rd("deep gate reserved", dscg_pkg::DEEP_GATE_OFS, 32'h0000_0000);
      apb(1'b1, 12'h120, 32'hFFFF_FFFF, d, e);
      chk("unmapped write error", 32'h0000_0001, {31'h0, e});
      apb(1'b0, 12'h128, 32'h0000_0000, d, e);
      chk("unmapped read error", 32'h0000_0001, {31'h0, e});
      chk("unmapped read data", 32'h0000_0000, d);
      rd("deep gate kept", dscg_pkg::DEEP_GATE_OFS, 32'h0000_0000);
      $display("test regmap done");
   endtask

   // Accesses to gated and clocked units, with the fault interrupt.
   task automatic t_fault();
      int p;
      wr(dscg_pkg::RUN_GATE_OFS, 32'h0000_0001);
      tick(3);
      access(7'h01, p);
      chk("fault on clocked unit", 32'h0000_0000, p);
      access(7'h02, p);
      chk("fault on gated unit", 32'h0000_0001, p);
      tick(3);
      chk("masked fault irq", 32'h0000_0000, {31'h0, irq});
      wr(dscg_pkg::IRQ_MASK_OFS, 32'h0000_0001);
      tick(3);
      chk("fault irq", 32'h0000_0001, {31'h0, irq});
      rd("fault status", dscg_pkg::IRQ_STAT_OFS, 32'h0000_0001);
      wr(dscg_pkg::IRQ_STAT_OFS, 32'h0000_0001);
      tick(3);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      rd("status cleared", dscg_pkg::IRQ_STAT_OFS, 32'h0000_0000);
      $display("test fault done");
   endtask

   // Bank selection by power state and auto clock gating.
   task automatic t_modes();
      wr(dscg_pkg::DEEP_GATE_OFS, 32'h0300_0000);
      wr(dscg_pkg::SLEEP_GATE_OFS, 32'h0001_0000);
      wr(dscg_pkg::RUN_GATE_OFS, 32'h0000_0011);
      deepSleepReq <= 1'b1;
      tick(4);
      chk("mode without gating", 32'h0000_0001, {29'h0, powerMode});
      chk("run enables", 32'h0000_0003, {25'h0, unitClkEn});
      wr(dscg_pkg::IRQ_MASK_OFS, 32'h0000_0006);
      wr(dscg_pkg::CTRL_OFS, 32'h0000_0001);
      tick(4);
      chk("deep mode", 32'h0000_0004, {29'h0, powerMode});
      chk("deep enables", 32'h0000_0060, {25'h0, unitClkEn});
      chk("deep entry irq", 32'h0000_0001, {31'h0, irq});
      for (int k = 0; k < 7; k++) begin
         wr(dscg_pkg::DEEP_GATE_OFS, 32'h0000_0001 << unitPos[k]);
         tick(3);
         chk("deep unit enable", 32'h0000_0001 << k, {25'h0, unitClkEn});
      end
      deepSleepReq <= 1'b0;
      tick(4);
      chk("woken mode", 32'h0000_0001, {29'h0, powerMode});
      chk("restored enables", 32'h0000_0003, {25'h0, unitClkEn});
      rd("mode status", dscg_pkg::IRQ_STAT_OFS, 32'h0000_0006);
      wr(dscg_pkg::IRQ_STAT_OFS, 32'h0000_0006);
      tick(3);
      chk("mode irq cleared", 32'h0000_0000, {31'h0, irq});
      sleepReq <= 1'b1;
      tick(4);
      chk("sleep mode", 32'h0000_0002, {29'h0, powerMode});
      chk("sleep enables", 32'h0000_0004, {25'h0, unitClkEn});
      wr(dscg_pkg::CTRL_OFS, 32'h0000_0000);
      tick(4);
      chk("gating off mode", 32'h0000_0001, {29'h0, powerMode});
      chk("gating off enables", 32'h0000_0003, {25'h0, unitClkEn});
      sleepReq <= 1'b0;
      $display("test modes done");
   endtask

   // ==========================================================================
   // Main sequence: inputs at time zero, reset for 20 cycles, then the scenarios.
   initial begin
      sys_clk      = 1'b0;
      rstn         = 1'b0;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 12'h000;
      pwdata       = 32'h0000_0000;
      sleepReq     = 1'b0;
      deepSleepReq = 1'b0;
      unitSel      = 7'h00;
      unitAccess   = 1'b0;
      failures     = 0;
      n_tests      = 0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_regmap();
      t_fault();
      t_modes();
      test_done();
   end

   // Cuts a hang short after 100000 cycles.
   initial begin
      #500000;
      failures++;
      test_done();
   end
endmodule // test_deep_sleep_clock_gating_reg1
`default_nettype wire
